// ==== design/preset_counter_cfg.svh ====
// Constants for the multimode preset counter
`ifndef PRESET_COUNTER_CFG_SVH
`define PRESET_COUNTER_CFG_SVH

`define ADR_CONFIG      8'h00
`define ADR_SETVAL1     8'h04
`define ADR_SETVAL2     8'h08
`define ADR_BATCHSET    8'h0C
`define ADR_DUALSET     8'h10
`define ADR_SHOTTIME    8'h14
`define ADR_PRESENT     8'h18
`define ADR_TOTAL       8'h1C
`define ADR_BATCHCNT    8'h20
`define ADR_CHAN1       8'h24
`define ADR_CHAN2       8'h28
`define ADR_DUALCNT     8'h2C
`define ADR_STATUS      8'h30
`define ADR_COMMAND     8'h34
`define ADR_RESTORE     8'h38

`define CFG_CONFIG_LSB  0
`define CFG_OUTMODE_LSB 3
`define CFG_SUB_BIT     5
`define CFG_STAGE2_BIT  6
`define CFG_DIG4_BIT    7

`define FULL_SCALE_6    20'd999999
`define FULL_SCALE_4    20'd9999
`define DUAL_MIN_6      21'sd99999
`define SHOT_TICK_NS    10000000
`define CLK_PERIOD_NS   50
`define SHOT_TICK_CYC   (`SHOT_TICK_NS / `CLK_PERIOD_NS)
`define SHOT_MAX        14'd9999
`define SHOT_RESET      14'd50

`endif

// ==== design/preset_counter_pkg.sv ====
// Types for the multimode preset counter
package preset_counter_pkg;

    typedef enum logic [2:0] {
        CfgSingle,
        CfgTwoStage,
        CfgTotal,
        CfgBatch,
        CfgDual
    } config_e;

    typedef enum logic [1:0] {
        OutHold,
        OutShot,
        OutLevel
    } outmode_e;

    typedef struct packed {
        logic [7:0]  adr;
        logic        we;
        logic [31:0] dat;
    } bus_req_s;

endpackage

// ==== design/multimode_preset_counter.sv ====
// Multimode preset counter core with a Wishbone register slave
// Operation
// - Compare present count to set values, drive outputs
// - Batch mode counts completions, sets batch output
// - Dual count adds or subtracts channel counts
// - Dual count reaching set value drives outputs
// - Both outputs switch together in the paired build (twoStage bit) except two-stage/batch
// - Present count wraps at full scale to zero
// - No counting while first reset held (dual: first channel only)
// - First reset ends one-shot pulse at once outside dual mode
// - Outputs on at power loss return after recovery
// - One-shot time 0.01 to 99.99 s
// - Total counter separate from preset resets
// - Batch count held zero during batch reset
// - Batch set zero counts; only a recovery restore turns the batch output on
// - Batch count wraps at full scale
// - Batch output retained across power loss
// - Lowering batch set below count sets output
// - Batch output stays on when set raised
// - Dual reset blocks one channel, uses zero
// - Dual range limits; channel overflow stops counting
// - First reset clears present count and outputs (dual: first channel only; batch keeps first output)
// - Second reset clears total or second channel
// - Batch second reset clears batch count and output
`timescale 1ns/1ps
`include "preset_counter_cfg.svh"
module multimode_preset_counter #(
    parameter int SHOT_TICK = `SHOT_TICK_CYC
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Sensor and reset inputs, one-cycle count pulses
    input  wire logic        firstCountChannel,
    input  wire logic        secondCountChannel,
    input  wire logic        resetOne,
    input  wire logic        resetTwo,
    // Control outputs
    output logic             firstControlOutput,
    output logic             secondControlOutput
);

    // A tick shorter than one cycle cannot pace the pulse timer
    if (SHOT_TICK < 1) begin : g_badTick
        $error("SHOT_TICK must be at least one cycle");
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0]  cfg_ff, nxt_cfg;
    logic [19:0] set1_ff, nxt_set1, set2_ff, nxt_set2;
    logic [19:0] batchSet_ff, nxt_batchSet;
    logic [20:0] dualSet_ff, nxt_dualSet;
    logic [13:0] shotTime_ff, nxt_shotTime;
    logic [19:0] present_ff, nxt_present, total_ff, nxt_total;
    logic [19:0] batch_ff, nxt_batch, chan1_ff, nxt_chan1;
    logic [19:0] chan2_ff, nxt_chan2;
    logic        first_control_output_ff, nxt_first_control_output, second_control_output_ff, nxt_second_control_output;
    logic        shot1_ff, nxt_shot1, shot2_ff, nxt_shot2;
    logic        ovf_ff, nxt_ovf;
    logic [13:0] shotCnt1_ff, nxt_shotCnt1, shotCnt2_ff, nxt_shotCnt2;
    logic [31:0] tick_ff, nxt_tick;
    logic [31:0] rdat_ff, nxt_rdat;
    logic        ack_ff, nxt_ack;

    ////////////////////////////////////////////////////////////////////////
    // Decoded configuration
    preset_counter_pkg::config_e  mode;
    preset_counter_pkg::outmode_e omode;
    preset_counter_pkg::bus_req_s req;
    logic [19:0] fullScale;
    logic        isSub, twoStage;
    logic signed [21:0] dualVal;
    logic        hit;

    always_comb begin
        mode  = preset_counter_pkg::config_e'(cfg_ff[2:0]);
        omode = preset_counter_pkg::outmode_e'(cfg_ff[4:3]);
        isSub    = cfg_ff[`CFG_SUB_BIT];
        twoStage = cfg_ff[`CFG_STAGE2_BIT];
        fullScale = cfg_ff[`CFG_DIG4_BIT] ? `FULL_SCALE_4 : `FULL_SCALE_6;
        req.adr = wb_adr_i;
        req.we  = wb_we_i;
        req.dat = wb_dat_i;
        // Reset channels count as zero in the dual result
        if (isSub) begin
            dualVal = (resetOne ? 22'sd0 : $signed({2'b00, chan1_ff}))
                    - (resetTwo ? 22'sd0 : $signed({2'b00, chan2_ff}));
        end else begin
            dualVal = (resetOne ? 22'sd0 : $signed({2'b00, chan1_ff}))
                    + (resetTwo ? 22'sd0 : $signed({2'b00, chan2_ff}));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counting and output logic
    logic wr, rd, cmdReset, restore, tick;
    logic [19:0] incP;
    logic        done1, done2;

    always_comb begin
        wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_ff;
        rd = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_ff;
        cmdReset = wr && req.adr == `ADR_COMMAND && req.dat[0];
        restore  = wr && req.adr == `ADR_RESTORE;
        tick = (tick_ff == 32'(SHOT_TICK - 1));
        nxt_tick = tick ? 32'h0 : tick_ff + 32'h1;

        nxt_cfg = cfg_ff;
        nxt_set1 = set1_ff;
        nxt_set2 = set2_ff;
        nxt_batchSet = batchSet_ff;
        nxt_dualSet = dualSet_ff;
        nxt_shotTime = shotTime_ff;
        if (wr) begin
            unique case (req.adr)
                `ADR_CONFIG:   nxt_cfg = req.dat[7:0];
                `ADR_SETVAL1:  nxt_set1 = req.dat[19:0];
                `ADR_SETVAL2:  nxt_set2 = req.dat[19:0];
                `ADR_BATCHSET: nxt_batchSet = req.dat[19:0];
                `ADR_DUALSET:  nxt_dualSet = req.dat[20:0];
                `ADR_SHOTTIME: begin
                    // Clamp to 1..9999 hundredths
                    if (req.dat > 32'(`SHOT_MAX)) begin
                        nxt_shotTime = `SHOT_MAX;
                    end else if (req.dat[13:0] == 14'h0000) begin
                        nxt_shotTime = 14'h0001;
                    end else begin
                        nxt_shotTime = req.dat[13:0];
                    end
                end
                default: ;
            endcase
        end

        nxt_present = present_ff;
        nxt_total = total_ff;
        nxt_batch = batch_ff;
        nxt_chan1 = chan1_ff;
        nxt_chan2 = chan2_ff;
        nxt_ovf = ovf_ff;
        done1 = 1'b0;
        done2 = 1'b0;
        incP = (present_ff >= fullScale) ? 20'h0 : present_ff + 20'h1;

        if (mode == preset_counter_pkg::CfgDual) begin
            if (!ovf_ff && firstCountChannel && !resetOne) begin
                if (chan1_ff >= fullScale) begin
                    nxt_ovf = 1'b1;
                end else begin
                    nxt_chan1 = chan1_ff + 20'h1;
                end
            end
            if (!ovf_ff && secondCountChannel && !resetTwo) begin
                if (chan2_ff >= fullScale) begin
                    nxt_ovf = 1'b1;
                end else begin
                    nxt_chan2 = chan2_ff + 20'h1;
                end
            end
            done2 = (dualVal == {dualSet_ff[20], dualSet_ff});
            done1 = done2;
        end else if (firstCountChannel && !resetOne) begin
            nxt_present = incP;
            if (mode == preset_counter_pkg::CfgTotal) begin
                nxt_total = (total_ff >= fullScale) ? 20'h0
                          : total_ff + 20'h1;
            end
            done2 = (incP == set2_ff);
            done1 = (mode == preset_counter_pkg::CfgTwoStage)
                  ? (incP == set1_ff) : done2;
            if (mode == preset_counter_pkg::CfgBatch && done2) begin
                nxt_batch = (batch_ff >= fullScale) ? 20'h0
                          : batch_ff + 20'h1;
            end
        end
        if (mode == preset_counter_pkg::CfgBatch) begin
            done1 = 1'b0;
        end

        // Resets
        if (resetOne || cmdReset) begin
            if (mode == preset_counter_pkg::CfgDual) begin
                nxt_chan1 = 20'h0;
                nxt_ovf = 1'b0;
            end else begin
                nxt_present = 20'h0;
            end
        end
        if (resetTwo || cmdReset) begin
            unique case (mode)
                preset_counter_pkg::CfgTotal: nxt_total = 20'h0;
                preset_counter_pkg::CfgBatch: nxt_batch = 20'h0;
                preset_counter_pkg::CfgDual: begin
                    nxt_chan2 = 20'h0;
                    nxt_ovf = 1'b0;
                end
                default: ;
            endcase
        end

        // Second output: main output for every configuration
        nxt_second_control_output = second_control_output_ff;
        nxt_shot2 = shot2_ff;
        nxt_shotCnt2 = shotCnt2_ff;
        if (shot2_ff && tick) begin
            if (shotCnt2_ff <= 14'h0001) begin
                nxt_second_control_output = 1'b0;
                nxt_shot2 = 1'b0;
            end else begin
                nxt_shotCnt2 = shotCnt2_ff - 14'h0001;
            end
        end
        if (omode == preset_counter_pkg::OutLevel
            && mode == preset_counter_pkg::CfgDual) begin
            nxt_second_control_output = (dualVal >= $signed({dualSet_ff[20], dualSet_ff}));
        end else if (done2) begin
            nxt_second_control_output = 1'b1;
            nxt_shot2 = (omode == preset_counter_pkg::OutShot);
            nxt_shotCnt2 = shotTime_ff;
        end

        // First output: separate stage, batch output, or mirror
        nxt_first_control_output = first_control_output_ff;
        nxt_shot1 = shot1_ff;
        nxt_shotCnt1 = shotCnt1_ff;
        if (mode == preset_counter_pkg::CfgBatch) begin
            nxt_shot1 = 1'b0;
            // Sticky once set; zero set value never fires
            if (batchSet_ff != 20'h0 && nxt_batch >= batchSet_ff) begin
                nxt_first_control_output = 1'b1;
            end
        end else if (twoStage && mode != preset_counter_pkg::CfgTwoStage) begin
            nxt_first_control_output = nxt_second_control_output;
            nxt_shot1 = 1'b0;
        end else begin
            if (shot1_ff && tick) begin
                if (shotCnt1_ff <= 14'h0001) begin
                    nxt_first_control_output = 1'b0;
                    nxt_shot1 = 1'b0;
                end else begin
                    nxt_shotCnt1 = shotCnt1_ff - 14'h0001;
                end
            end
            if (done1) begin
                nxt_first_control_output = 1'b1;
                nxt_shot1 = (omode == preset_counter_pkg::OutShot);
                nxt_shotCnt1 = shotTime_ff;
            end
        end
        if (resetOne || cmdReset) begin
            if (mode != preset_counter_pkg::CfgDual) begin
                nxt_second_control_output = 1'b0;
                nxt_shot2 = 1'b0;
                if (mode != preset_counter_pkg::CfgBatch) begin
                    nxt_first_control_output = 1'b0;
                    nxt_shot1 = 1'b0;
                end
            end
        end
        if ((resetTwo || cmdReset) && mode == preset_counter_pkg::CfgBatch) begin
            nxt_first_control_output = 1'b0;
        end
        // Recovery restore: relaunch outputs from saved state
        if (restore) begin
            if (req.dat[1]) begin
                nxt_second_control_output = 1'b1;
                nxt_shot2 = (omode == preset_counter_pkg::OutShot);
                nxt_shotCnt2 = shotTime_ff;
            end
            if (req.dat[0]) begin
                nxt_first_control_output = 1'b1;
                nxt_shot1 = (omode == preset_counter_pkg::OutShot)
                          && mode != preset_counter_pkg::CfgBatch;
                nxt_shotCnt1 = shotTime_ff;
            end
        end
        // Paired build: first output follows the second on every path
        if (twoStage && mode != preset_counter_pkg::CfgTwoStage
            && mode != preset_counter_pkg::CfgBatch) begin
            nxt_first_control_output = nxt_second_control_output;
            nxt_shot1 = 1'b0;
        end

        // Bus read and ack
        nxt_ack = (wb_cyc_i && wb_stb_i && !ack_ff);
        nxt_rdat = 32'h0;
        if (rd) begin
            unique case (req.adr)
                `ADR_CONFIG:   nxt_rdat = {24'h0, cfg_ff};
                `ADR_SETVAL1:  nxt_rdat = {12'h0, set1_ff};
                `ADR_SETVAL2:  nxt_rdat = {12'h0, set2_ff};
                `ADR_BATCHSET: nxt_rdat = {12'h0, batchSet_ff};
                `ADR_DUALSET:  nxt_rdat = {{11{dualSet_ff[20]}}, dualSet_ff};
                `ADR_SHOTTIME: nxt_rdat = {18'h0, shotTime_ff};
                `ADR_PRESENT:  nxt_rdat = {12'h0, present_ff};
                `ADR_TOTAL:    nxt_rdat = {12'h0, total_ff};
                `ADR_BATCHCNT: nxt_rdat = {12'h0, batch_ff};
                `ADR_CHAN1:    nxt_rdat = {12'h0, chan1_ff};
                `ADR_CHAN2:    nxt_rdat = {12'h0, chan2_ff};
                `ADR_DUALCNT:  nxt_rdat = {{10{dualVal[21]}}, dualVal};
                `ADR_STATUS:   nxt_rdat = {27'h0, ovf_ff, shot2_ff,
                                           shot1_ff, second_control_output_ff, first_control_output_ff};
                default:       nxt_rdat = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_ff <= 8'h00;
            set1_ff <= 20'h0;
            set2_ff <= 20'h0;
            batchSet_ff <= 20'h0;
            dualSet_ff <= 21'h0;
            shotTime_ff <= `SHOT_RESET;
            present_ff <= 20'h0;
            total_ff <= 20'h0;
            batch_ff <= 20'h0;
            chan1_ff <= 20'h0;
            chan2_ff <= 20'h0;
            first_control_output_ff <= 1'b0;
            second_control_output_ff <= 1'b0;
            shot1_ff <= 1'b0;
            shot2_ff <= 1'b0;
            ovf_ff <= 1'b0;
            shotCnt1_ff <= 14'h0;
            shotCnt2_ff <= 14'h0;
            tick_ff <= 32'h0;
            rdat_ff <= 32'h0;
            ack_ff <= 1'b0;
        end else begin
            cfg_ff <= nxt_cfg;
            set1_ff <= nxt_set1;
            set2_ff <= nxt_set2;
            batchSet_ff <= nxt_batchSet;
            dualSet_ff <= nxt_dualSet;
            shotTime_ff <= nxt_shotTime;
            present_ff <= nxt_present;
            total_ff <= nxt_total;
            batch_ff <= nxt_batch;
            chan1_ff <= nxt_chan1;
            chan2_ff <= nxt_chan2;
            first_control_output_ff <= nxt_first_control_output;
            second_control_output_ff <= nxt_second_control_output;
            shot1_ff <= nxt_shot1;
            shot2_ff <= nxt_shot2;
            ovf_ff <= nxt_ovf;
            shotCnt1_ff <= nxt_shotCnt1;
            shotCnt2_ff <= nxt_shotCnt2;
            tick_ff <= nxt_tick;
            rdat_ff <= nxt_rdat;
            ack_ff <= nxt_ack;
        end
    end

    assign wb_dat_o = rdat_ff;
    assign wb_ack_o = ack_ff;
    assign firstControlOutput = first_control_output_ff;
    assign secondControlOutput = second_control_output_ff;

endmodule

// ==== dv/pulse_source_model.sv ====
// Model of the pulse sensors and reset switches on the counter inputs
`timescale 1ns/1ps
module pulse_source_model (
    // Clock
    input  wire logic clk,
    // Sensor and switch lines
    output logic      chanOne,
    output logic      chanTwo,
    output logic      rstOne,
    output logic      rstTwo
);
    initial begin
        chanOne = 1'b0;
        chanTwo = 1'b0;
        rstOne  = 1'b0;
        rstTwo  = 1'b0;
    end
    task automatic drive(input int ch, input logic v);
        if (ch == 1) chanOne <= v;
        else chanTwo <= v;
    endtask
    // Counts one cycle wide, with gap idle cycles after each (slow sensor)
    task automatic pulses(input int ch, input int n, input int gap);
        repeat (n) begin
            @(posedge clk);
            drive(ch, 1'b1);
            repeat (gap) begin
                @(posedge clk);
                drive(ch, 1'b0);
            end
        end
        @(posedge clk);
        drive(ch, 1'b0);
    endtask
    task automatic hold(input int which, input int n);
        @(posedge clk);
        if (which == 1) rstOne <= 1'b1;
        else rstTwo <= 1'b1;
        repeat (n) @(posedge clk);
        if (which == 1) rstOne <= 1'b0;
        else rstTwo <= 1'b0;
    endtask
endmodule

// ==== dv/multimode_preset_counter_sva.sv ====
// Port checks for the multimode preset counter
`timescale 1ns/1ps
`include "preset_counter_cfg.svh"
module multimode_preset_counter_sva #(
    parameter int SHOT_TICK = 2
) (
    // Clock, reset and bus
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Sensors and outputs
    input wire logic        firstCountChannel,
    input wire logic        secondCountChannel,
    input wire logic        resetOne,
    input wire logic        resetTwo,
    input wire logic        firstControlOutput,
    input wire logic        secondControlOutput
);
    logic [7:0]  cfg_ff, nxt_cfg;
    logic [13:0] shot_ff, nxt_shot;
    int          hiCnt_ff, nxt_hiCnt;
    logic        take, keyTake, oOne, oTwo;
    logic [2:0]  mode;
    logic [1:0]  omode;
    assign take    = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i;
    assign keyTake = take && wb_adr_i inside {`ADR_CONFIG, `ADR_COMMAND};
    assign mode    = cfg_ff[2:0];
    assign omode   = cfg_ff[4:3];
    assign oOne    = firstControlOutput;
    assign oTwo    = secondControlOutput;
    // Shadow of mode and pulse time, and length of the current pulse
    always_comb begin
        nxt_cfg   = cfg_ff;
        nxt_shot  = shot_ff;
        nxt_hiCnt = oTwo ? hiCnt_ff + 1 : 0;
        if (take && wb_adr_i == `ADR_CONFIG) nxt_cfg = wb_dat_i[7:0];
        if (take && wb_adr_i == `ADR_SHOTTIME) begin
            nxt_shot = wb_dat_i > 32'h0000270F ? `SHOT_MAX : wb_dat_i[13:0];
            if (wb_dat_i == 32'h0) nxt_shot = 14'h0001;
        end
        if (rst) begin
            nxt_cfg   = 8'h00;
            nxt_shot  = `SHOT_RESET;
            nxt_hiCnt = 0;
        end
    end
    always_ff @(posedge clk) begin
        cfg_ff   <= nxt_cfg;
        shot_ff  <= nxt_shot;
        hiCnt_ff <= nxt_hiCnt;
    end
    ////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence busReq;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence shotEnd;
        omode == 2'h1 && $fell(oTwo) && !$past(resetOne);
    endsequence
    chk_ack_once: assert property (busReq |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack is not one pulse one cycle after a request");
    chk_ack_idle: assert property (!wb_cyc_i |=> !wb_ack_o)
        else $error("ack without a request");
    chk_rst_quiet: assert property (@(posedge clk) disable iff (1'b0)
        rst |=> !wb_ack_o && !oOne && !oTwo) else $error("active after reset");
    chk_outs_pair: assert property (
        cfg_ff[6] && mode inside {3'h0, 3'h2, 3'h4} && $stable(cfg_ff)
        |-> oOne == oTwo) else $error("outputs differ");
    chk_reset_clears: assert property (
        resetOne && mode < 3'h3 |=> !oOne && !oTwo)
        else $error("first reset left an output on");
    chk_shot_cut: assert property (
        omode == 2'h1 && mode != 3'h4 && resetOne |=> !oTwo)
        else $error("pulse not ended by first reset");
    chk_shot_width: assert property (shotEnd |->
        hiCnt_ff > (int'(shot_ff) - 1) * SHOT_TICK &&
        hiCnt_ff <= int'(shot_ff) * SHOT_TICK + 1) else $error("pulse width");
    chk_batch_keep: assert property (mode == 3'h3 && omode == 2'h0 &&
        oOne && !resetOne && !resetTwo && !keyTake |=> oOne)
        else $error("batch output dropped");
    chk_batch_clear: assert property (
        mode == 3'h3 && resetTwo |=> !oOne) else $error("batch output kept");
    chk_hold_latch: assert property (omode == 2'h0 && oTwo &&
        !resetOne && !resetTwo && !keyTake |=> oTwo)
        else $error("held output dropped");
endmodule
bind multimode_preset_counter multimode_preset_counter_sva #(
    .SHOT_TICK(SHOT_TICK)
) u_sva (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .firstCountChannel(firstCountChannel), .resetOne(resetOne),
    .secondCountChannel(secondCountChannel), .resetTwo(resetTwo),
    .firstControlOutput(firstControlOutput),
    .secondControlOutput(secondControlOutput));

// ==== dv/test_multimode_preset_counter.sv ====
// Self-checking bench for the multimode preset counter
`timescale 1ns/1ps
`include "preset_counter_cfg.svh"
module test_multimode_preset_counter;
    logic        clk, rst, wbCyc, wbStb, wbWe, wbAck;
    logic [7:0]  wbAdr;
    logic [31:0] wbDatW, wbDatR, rdData;
    logic        chanOne, chanTwo, rstOne, rstTwo, outOne, outTwo;
    int          fail_count, cmp_count;
    multimode_preset_counter #(.SHOT_TICK(4)) u_multimode_preset_counter (
        .clk(clk), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF),
        .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
        .firstCountChannel(chanOne), .secondCountChannel(chanTwo),
        .resetOne(rstOne), .resetTwo(rstTwo),
        .firstControlOutput(outOne), .secondControlOutput(outTwo));
    pulse_source_model u_pulse_source_model (.clk(clk), .chanOne(chanOne),
        .chanTwo(chanTwo), .rstOne(rstOne), .rstTwo(rstTwo));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        wbCyc  <= 1'b1;
        wbStb  <= 1'b1;
        wbWe   <= w;
        wbAdr  <= a;
        wbDatW <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        rdData = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        if (n >= 20) begin
            check(32'h0, 32'h1);
            print_verdict();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h0);
        check(rdData & (a == `ADR_DUALCNT ? 32'h001FFFFF : 32'hFFFFFFFF), e);
    endtask
    task automatic outs(input logic [1:0] e);
        repeat (3) @(posedge clk);
        check({30'h0, outOne, outTwo}, {30'h0, e});
    endtask
    task automatic restart();
        @(posedge clk);
        rst <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
    endtask
    task automatic complete(input int n);
        repeat (n) begin
            u_pulse_source_model.hold(1, 1);
            u_pulse_source_model.pulses(1, 2, 0);
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        {wbCyc, wbStb, wbWe, wbAdr, wbDatW} = '0;
        fail_count = 0;
        cmp_count = 0;
        restart();
        rd(`ADR_SHOTTIME, 32'h32);
        wr(8'h3C, 32'hFFFF);
        rd(8'h3C, 32'h0);
        wr(`ADR_SHOTTIME, 32'h0);
        rd(`ADR_SHOTTIME, 32'h1);
        wr(`ADR_SHOTTIME, 32'h4E20);
        rd(`ADR_SHOTTIME, 32'h270F);
        // Single counter, hold mode, two-stage build
        wr(`ADR_CONFIG, 32'h40);
        wr(`ADR_SETVAL2, 32'h5);
        u_pulse_source_model.pulses(1, 4, 1);
        outs(2'b00);
        u_pulse_source_model.pulses(1, 1, 0);
        outs(2'b11);
        u_pulse_source_model.hold(2, 3);
        rd(`ADR_PRESENT, 32'h5);
        fork
            u_pulse_source_model.hold(1, 6);
            u_pulse_source_model.pulses(1, 3, 0);
        join
        outs(2'b00);
        rd(`ADR_PRESENT, 32'h0);
        wr(`ADR_CONFIG, 32'hC0);
        u_pulse_source_model.pulses(1, 9999, 0);
        rd(`ADR_PRESENT, 32'h270F);
        u_pulse_source_model.pulses(1, 1, 0);
        rd(`ADR_PRESENT, 32'h0);
        // One-shot pulse, relaunch and cut
        restart();
        wr(`ADR_CONFIG, 32'h48);
        wr(`ADR_SHOTTIME, 32'h3);
        wr(`ADR_SETVAL2, 32'h2);
        u_pulse_source_model.pulses(1, 2, 0);
        outs(2'b11);
        repeat (30) @(posedge clk);
        outs(2'b00);
        wr(`ADR_RESTORE, 32'h3);
        outs(2'b11);
        u_pulse_source_model.hold(1, 1);
        outs(2'b00);
        // Total counter
        restart();
        wr(`ADR_CONFIG, 32'h42);
        u_pulse_source_model.pulses(1, 3, 1);
        u_pulse_source_model.hold(1, 2);
        u_pulse_source_model.pulses(1, 2, 0);
        rd(`ADR_PRESENT, 32'h2);
        rd(`ADR_TOTAL, 32'h5);
        u_pulse_source_model.hold(2, 2);
        rd(`ADR_TOTAL, 32'h0);
        rd(`ADR_PRESENT, 32'h2);
        // Batch counter
        restart();
        wr(`ADR_CONFIG, 32'h03);
        wr(`ADR_SETVAL2, 32'h2);
        wr(`ADR_BATCHSET, 32'h2);
        complete(1);
        outs(2'b01);
        complete(1);
        rd(`ADR_BATCHCNT, 32'h2);
        outs(2'b11);
        wr(`ADR_BATCHSET, 32'h5);
        outs(2'b11);
        u_pulse_source_model.hold(2, 3);
        rd(`ADR_BATCHCNT, 32'h0);
        rd(`ADR_PRESENT, 32'h2);
        fork
            u_pulse_source_model.hold(2, 12);
            complete(1);
        join
        rd(`ADR_BATCHCNT, 32'h0);
        complete(2);
        outs(2'b01);
        wr(`ADR_BATCHSET, 32'h1);
        outs(2'b11);
        wr(`ADR_BATCHSET, 32'h0);
        u_pulse_source_model.hold(2, 2);
        complete(2);
        rd(`ADR_BATCHCNT, 32'h2);
        outs(2'b01);
        wr(`ADR_RESTORE, 32'h1);
        outs(2'b11);
        // Dual counter, add then subtract
        restart();
        wr(`ADR_CONFIG, 32'h44);
        wr(`ADR_DUALSET, 32'h5);
        fork
            u_pulse_source_model.pulses(1, 3, 0);
            u_pulse_source_model.pulses(2, 2, 1);
        join
        rd(`ADR_DUALCNT, 32'h5);
        outs(2'b11);
        u_pulse_source_model.hold(2, 2);
        rd(`ADR_CHAN2, 32'h0);
        rd(`ADR_CHAN1, 32'h3);
        wr(`ADR_CONFIG, 32'h64);
        fork
            u_pulse_source_model.hold(1, 6);
            u_pulse_source_model.pulses(1, 2, 0);
            u_pulse_source_model.pulses(2, 2, 0);
        join
        rd(`ADR_CHAN1, 32'h0);
        rd(`ADR_CHAN2, 32'h2);
        rd(`ADR_DUALCNT, 32'h1FFFFE);
        wr(`ADR_CONFIG, 32'h74);
        outs(2'b00);
        // Channel overflow stops all counting
        restart();
        wr(`ADR_CONFIG, 32'h84);
        u_pulse_source_model.pulses(1, 10000, 0);
        u_pulse_source_model.pulses(2, 2, 0);
        rd(`ADR_CHAN2, 32'h0);
        bus(`ADR_STATUS, 1'b0, 32'h0);
        check(rdData & 32'h10, 32'h10);
        print_verdict();
    end
endmodule
